//--- tcsc_conv_timer.sv
// Conversion interval timer: pulses once per elapsed conversion interval
`timescale 1ns/10ps
module tcsc_conv_timer #(
    parameter int unsigned CNT_W = tcsc_pkg::CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,                 // Counting while high, cleared while low
    input wire logic [CNT_W-1:0] limit,   // Interval length in cycles, at least 1
    output logic done                     // One-cycle pulse at interval end
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count; // Cycles elapsed in this interval
    logic [CNT_W-1:0] next_count;

    // Interval ends on the last counted cycle
    assign done = run && (count == limit - {{(CNT_W-1){1'b0}}, 1'b1});

    // Next count: wrap on done so back-to-back intervals need no gap
    always_comb
    begin
        next_count = count;
        if (!run || done)
        begin
            // Idle or wrapping
            next_count = '0;
        end
        else
        begin
            next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Register the counter
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

endmodule

//--- tcsc_ctrl.sv
// Conversion sequencing, result formatting and shutdown control
// Notes on behaviour
// - Conversions start by themselves after reset
// - Width select picks 9 to 12 bits
// - Width defaults to 9 bits after reset
// - Interval 150 ms at 9 bits, doubling per bit
// - Each finished conversion loads the result register
// - Bit 15 is the sign, two's complement
// - Result bits 3 to 0 always zero
// - Result left-justified, unused low bits zero
// - Bit 14 weighs 2^6, bit 4 weighs 2^-4
// - Reads never disturb the running conversion
// - Halt finishes and stores current conversion first
// - Halt entry clears alarm only in interrupt mode
// - Registers work in halt; clearing halt resumes
// - Alarm mode bit: 0 comparator, 1 interrupt
// - Halt bit resets to 0, 1 means halt
`timescale 1ns/10ps
module tcsc_ctrl #(
    // 9-bit interval in cycles; shorten for simulation
    parameter int unsigned CONV_9BIT_CYCLES = tcsc_pkg::CONV_9BIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_wr,              // Config byte write strobe
    input wire logic [7:0] cfg_wdata,     // Config byte write data
    input wire logic reg_rd,              // Any register read strobe
    input wire logic [11:0] sensor_sample, // Converter output, 12-bit two's complement
    input wire logic alarm_level,         // Comparator-mode alarm state
    input wire logic alarm_event,         // Interrupt-mode trip pulse
    output logic [15:0] temperature_result, // Latest finished result
    output logic [7:0] config_rdata,      // Config byte read value
    output logic conv_done,               // Pulse after a result is stored
    output logic halted,                  // In low power standby
    output logic alarm_active             // Logical alarm state, before polarity
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tcsc_pkg::tcsc_state_e state;        // Sequencer state
    tcsc_pkg::tcsc_state_e next_state;
    logic [6:0] cfg;                      // Stored config bits, reserved bit not kept
    logic [6:0] next_cfg;
    logic [1:0] conv_width;               // Width latched for the running conversion
    logic [1:0] next_conv_width;
    logic [15:0] next_result;
    logic next_conv_done;
    logic next_halted;
    logic next_alarm;
    logic [tcsc_pkg::CNT_W-1:0] limit;    // Interval for the latched width
    logic timer_run;                      // Timer counting
    logic timer_done;                     // Interval elapsed
    logic halt_bit;                       // Current halt request
    logic irq_mode;                       // Interrupt alarm mode selected
    logic [1:0] cfg_width;                // Width currently configured
    logic [15:0] width_mask;              // Kept bits for latched width
    logic enter_halt;                     // Standby entered this cycle

    // ------------------------------------------------------------
    // Config decode
    // ------------------------------------------------------------
    assign halt_bit = cfg[tcsc_pkg::CFG_HALT_BIT];
    assign irq_mode = cfg[tcsc_pkg::CFG_ALARM_MODE_BIT];
    assign cfg_width = {cfg[tcsc_pkg::CFG_WIDTH_HI_BIT],
                        cfg[tcsc_pkg::CFG_WIDTH_LO_BIT]};

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    // Interval doubles per extra bit of width
    assign limit = tcsc_pkg::CNT_W'(CONV_9BIT_CYCLES) << conv_width;
    // Counts in every converting cycle, from the first after reset
    assign timer_run = (state == tcsc_pkg::TCSC_CONVERT);

    tcsc_conv_timer #(
        .CNT_W(tcsc_pkg::CNT_W)
    ) tcsc_conv_timer_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(timer_run),
        .limit(limit),
        .done(timer_done)
    );

    // Kept-bit mask for the width in use
    always_comb
    begin
        unique case (conv_width)
            tcsc_pkg::WIDTH_9: width_mask = tcsc_pkg::MASK_9BIT;
            tcsc_pkg::WIDTH_10: width_mask = tcsc_pkg::MASK_10BIT;
            tcsc_pkg::WIDTH_11: width_mask = tcsc_pkg::MASK_11BIT;
            tcsc_pkg::WIDTH_12: width_mask = tcsc_pkg::MASK_12BIT;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Reads play no part here, so a conversion is never disturbed
    always_comb
    begin
        next_state = state;
        next_conv_width = conv_width;
        next_result = temperature_result;
        next_conv_done = 1'b0;
        next_halted = halted;
        enter_halt = 1'b0;
        unique case (state)
            tcsc_pkg::TCSC_CONVERT:
            begin
                if (timer_done)
                begin
                    // Sample is sign-extended by position: bit 15 is the sign,
                    // bit 4 weighs 2^-4; low nibble and unused bits cleared
                    next_result = {sensor_sample, 4'h0} & width_mask;
                    next_conv_done = 1'b1;
                    // New width only takes effect at an interval boundary
                    next_conv_width = cfg_width;
                    if (halt_bit)
                    begin
                        // Halt waits for this store, then stops
                        next_state = tcsc_pkg::TCSC_STANDBY;
                        next_halted = 1'b1;
                        enter_halt = 1'b1;
                    end
                    // Otherwise the timer wraps and the next one starts at once
                end
            end
            tcsc_pkg::TCSC_STANDBY:
            begin
                if (!halt_bit)
                begin
                    // Clearing halt resumes with the current width
                    next_state = tcsc_pkg::TCSC_CONVERT;
                    next_conv_width = cfg_width;
                    next_halted = 1'b0;
                end
            end
        endcase
    end

    // Register sequencer state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= tcsc_pkg::TCSC_CONVERT;
            conv_width <= tcsc_pkg::WIDTH_9;
            temperature_result <= tcsc_pkg::RESULT_RESET;
            conv_done <= 1'b0;
            halted <= 1'b0;
        end
        else
        begin
            state <= next_state;
            conv_width <= next_conv_width;
            temperature_result <= next_result;
            conv_done <= next_conv_done;
            halted <= next_halted;
        end
    end

    // ------------------------------------------------------------
    // Config register
    // ------------------------------------------------------------
    // Writes accepted in any state, standby included
    always_comb
    begin
        next_cfg = cfg;
        if (cfg_wr)
        begin
            next_cfg = cfg_wdata[6:0];
        end
    end

    // Register config and its read image
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cfg <= tcsc_pkg::CFG_RESET[6:0];
            config_rdata <= tcsc_pkg::CFG_RESET;
        end
        else
        begin
            cfg <= next_cfg;
            // Reserved top bit always reads zero
            config_rdata <= {1'b0, next_cfg} & tcsc_pkg::CFG_WRITE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Alarm output
    // ------------------------------------------------------------
    // Interrupt mode: a trip sets, a read or halt entry clears, and a trip
    // in the same cycle as a clear wins so no event is lost
    always_comb
    begin
        next_alarm = alarm_active;
        if (irq_mode)
        begin
            if (alarm_event)
            begin
                next_alarm = 1'b1;
            end
            else if (reg_rd || enter_halt)
            begin
                next_alarm = 1'b0;
            end
        end
        else if (!halted && !enter_halt)
        begin
            // Comparator mode follows the comparator, frozen in standby
            next_alarm = alarm_level;
        end
    end

    // Register alarm
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            alarm_active <= 1'b0;
        end
        else
        begin
            alarm_active <= next_alarm;
        end
    end

endmodule

//--- tcsc_ctrl_asserts.sv
// Port-level checks for the conversion and shutdown controller
`timescale 1ns/10ps
module tcsc_ctrl_asserts #(
    parameter int unsigned CONV_9BIT_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic reg_rd,
    input wire logic [11:0] sensor_sample,
    input wire logic alarm_level,
    input wire logic alarm_event,
    input wire logic [15:0] temperature_result,
    input wire logic [7:0] config_rdata,
    input wire logic conv_done,
    input wire logic halted,
    input wire logic alarm_active
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Longest interval, at 12-bit width
    localparam int N_MAX = CONV_9BIT_CYCLES * 8;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_low; temperature_result[3:0] == 4'h0; endproperty
    a_low: assert property (p_low) else $error("result low nibble set");
    property p_top; conv_done |-> temperature_result[15:7] == $past(sensor_sample[11:3]); endproperty
    a_top: assert property (p_top) else $error("result top bits wrong");
    property p_unused; conv_done |-> (temperature_result[6:4] & ~$past(sensor_sample[2:0])) == 3'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("result low bits wrong");
    property p_stable; !$stable(temperature_result) |-> conv_done; endproperty
    a_stable: assert property (p_stable) else $error("result moved alone");
    property p_first; $fell(rst) |-> !conv_done [*3] ##[1:3] conv_done; endproperty
    a_first: assert property (p_first) else $error("first result late");
    property p_cont; conv_done && !halted |-> ##[1:N_MAX] conv_done; endproperty
    a_cont: assert property (p_cont) else $error("conversions stopped");
    property p_entry; $rose(halted) |-> conv_done && $past(config_rdata[0]); endproperty
    a_entry: assert property (p_entry) else $error("bad standby entry");
    property p_quiet; halted && $past(halted) |-> !conv_done; endproperty
    a_quiet: assert property (p_quiet) else $error("result in standby");
    property p_irq; $rose(halted) && $past(config_rdata[1]) && !$past(alarm_event) |-> !alarm_active;
    endproperty
    a_irq: assert property (p_irq) else $error("alarm kept at standby");
    property p_resume; $fell(halted) |-> !config_rdata[0] ##[1:N_MAX] conv_done; endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_cfg; cfg_wr |=> config_rdata == {1'b0, $past(cfg_wdata[6:0])}; endproperty
    a_cfg: assert property (p_cfg) else $error("config write lost");
    property p_set; config_rdata[1] && alarm_event |=> alarm_active; endproperty
    a_set: assert property (p_set) else $error("alarm trip lost");
    property p_rdclr; config_rdata[1] && reg_rd && !alarm_event |=> !alarm_active; endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear alarm");
    property p_cmp; !config_rdata[1] && !halted |=> halted || alarm_active == $past(alarm_level);
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator alarm wrong");
    // Main scenarios reached
    c_done: cover property (conv_done);
    c_halt: cover property ($rose(halted));
    c_wake: cover property ($fell(halted));
endmodule

//--- tcsc_ctrl_tb.sv
// Self-checking bench for the conversion and shutdown controller
`timescale 1ns/10ps
module tcsc_ctrl_tb;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    localparam int unsigned CONV = 4; // Short 9-bit interval keeps runs brief
    logic sys_clk, rst, cfg_wr, reg_rd, alarm_level, alarm_event;
    logic conv_done, halted, alarm_active;
    logic [7:0] cfg_wdata, config_rdata;
    logic [11:0] sensor_sample;
    logic [15:0] temperature_result;
    int n_errors = 0;
    int n_checks = 0;
    tcsc_ctrl #(.CONV_9BIT_CYCLES(CONV)) tcsc_ctrl_inst (.sys_clk(sys_clk), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .reg_rd(reg_rd), .sensor_sample(sensor_sample),
        .alarm_level(alarm_level), .alarm_event(alarm_event), .halted(halted),
        .temperature_result(temperature_result), .config_rdata(config_rdata),
        .conv_done(conv_done), .alarm_active(alarm_active));
    tcsc_host_model tcsc_host_model_inst (.sys_clk(sys_clk), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .reg_rd(reg_rd));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Falling edges up to the next stored result, bounded
    task automatic wait_done(output int n);
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (conv_done !== 1'b1 && n < 100);
        // Bound ran out: no result arrived
        if (conv_done !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH conv_done expected 1 seen %b", conv_done);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int n;
        repeat (12) @(negedge sys_clk);
        chk("result", 16'h0000, temperature_result);
        chk("config", 16'h0000, {8'h00, config_rdata});
        rst = 1'b0;
        wait_done(n);
        chk("first", 16'(CONV), 16'(n));
        chk("plus125", 16'h7d00, temperature_result);
        $display("t_reset done");
    endtask
    // Widest first; two intervals pass so the new width is surely latched
    task automatic t_widths();
        int n;
        logic [15:0] mask;
        for (int w = 3; w >= 0; w--)
        begin
            mask = 16'hffff << (7 - w);
            tcsc_host_model_inst.write_cfg({1'b0, w[1:0], 5'h00});
            wait_done(n);
            sensor_sample = 12'hf5e;
            wait_done(n);
            fork
                wait_done(n);
                tcsc_host_model_inst.read_reg();
            join
            chk("interval", 16'(CONV << w), 16'(n));
            chk("masked", 16'hf5e0 & mask, temperature_result);
        end
        $display("t_widths done");
    endtask
    task automatic t_halt();
        int n;
        wait_done(n);
        sensor_sample = 12'hc90;
        tcsc_host_model_inst.write_cfg(8'h01);
        wait_done(n);
        chk("last", 16'hc900, temperature_result);
        chk("halted", 16'h0001, {15'h0, halted});
        n = 0;
        repeat (40)
        begin
            @(negedge sys_clk);
            n += int'(conv_done);
        end
        chk("quiet", 16'h0000, 16'(n));
        tcsc_host_model_inst.read_reg();
        chk("cfg_sd", 16'h0001, {8'h00, config_rdata});
        tcsc_host_model_inst.write_cfg(8'h00);
        wait_done(n);
        chk("resume", 16'(CONV + 1), 16'(n));
        $display("t_halt done");
    endtask
    task automatic t_alarm();
        int n;
        tcsc_host_model_inst.write_cfg(8'h02);
        alarm_event = 1'b1;
        @(negedge sys_clk);
        alarm_event = 1'b0;
        chk("irq_set", 16'h0001, {15'h0, alarm_active});
        tcsc_host_model_inst.read_reg();
        chk("irq_read", 16'h0000, {15'h0, alarm_active});
        alarm_event = 1'b1;
        wait_done(n);
        alarm_event = 1'b0;
        tcsc_host_model_inst.write_cfg(8'h03);
        wait_done(n);
        chk("irq_halt", 16'h0002, {14'h0, halted, alarm_active});
        tcsc_host_model_inst.write_cfg(8'h00);
        alarm_level = 1'b1;
        wait_done(n);
        tcsc_host_model_inst.write_cfg(8'h01);
        wait_done(n);
        alarm_level = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("cmp_halt", 16'h0003, {14'h0, halted, alarm_active});
        tcsc_host_model_inst.write_cfg(8'h00);
        repeat (5) @(negedge sys_clk);
        chk("cmp_run", 16'h0000, {14'h0, halted, alarm_active});
        // Stored-only bits kept, reserved bit dropped
        tcsc_host_model_inst.write_cfg(8'h9c);
        chk("cfg_rsvd", 16'h001c, {8'h00, config_rdata});
        $display("t_alarm done");
    endtask
    // Reset mid 9-bit interval with 12-bit width written but not yet latched, and a live alarm: all back to defaults
    task automatic t_rerst();
        int n;
        tcsc_host_model_inst.write_cfg(8'h62);
        alarm_event = 1'b1;
        @(negedge sys_clk);
        alarm_event = 1'b0;
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("rerst_result", 16'h0000, temperature_result);
        chk("rerst_config", 16'h0000, {8'h00, config_rdata});
        chk("rerst_flags", 16'h0000, {14'h0, halted, alarm_active});
        sensor_sample = 12'hf5e;
        rst = 1'b0;
        wait_done(n);
        chk("rerst_first", 16'(CONV), 16'(n));
        chk("rerst_width", 16'hf580, temperature_result);
        $display("t_rerst done");
    endtask
    initial
    begin
        rst = 1'b1;
        sensor_sample = 12'h7d0;
        alarm_level = 1'b0;
        alarm_event = 1'b0;
        t_reset();
        t_widths();
        t_halt();
        t_alarm();
        t_rerst();
        give_verdict();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial
    begin
        #50000;
        n_errors++;
        give_verdict();
    end
endmodule
bind tcsc_ctrl tcsc_ctrl_asserts #(.CONV_9BIT_CYCLES(CONV_9BIT_CYCLES)) tcsc_ctrl_asserts_inst (
    .sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .reg_rd(reg_rd),
    .sensor_sample(sensor_sample), .alarm_level(alarm_level), .alarm_event(alarm_event),
    .temperature_result(temperature_result), .config_rdata(config_rdata),
    .conv_done(conv_done), .halted(halted), .alarm_active(alarm_active));

//--- tcsc_host_model.sv
// Bus controller stand-in issuing config writes and register reads
`timescale 1ns/10ps
module tcsc_host_model (
    input wire logic sys_clk,
    output logic cfg_wr,
    output logic [7:0] cfg_wdata,
    output logic reg_rd
);
    // Idle strobes at time zero
    initial
    begin
        cfg_wr = 1'b0;
        cfg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One-cycle write; data inverted after so a stale byte never looks live
    task automatic write_cfg(input logic [7:0] b);
        @(negedge sys_clk);
        cfg_wdata = b;
        cfg_wr = 1'b1;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        cfg_wdata = ~b;
    endtask
    // One-cycle read strobe, also used in standby
    task automatic read_reg();
        @(negedge sys_clk);
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
    endtask
endmodule

//--- tcsc_pkg.sv
// Shared constants for the thermometer conversion and shutdown controller
package tcsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Clock rate of sys_clk in Hz
    localparam int unsigned CLK_HZ = 125_000_000;
    // Longest conversion time at 9-bit width, in ms
    localparam int unsigned CONV_9BIT_MS = 150;
    // Cycles per 9-bit conversion; longest time, so rounded down
    localparam int unsigned CONV_9BIT_CYCLES = CONV_9BIT_MS * (CLK_HZ / 1000);
    // Width of the conversion cycle counter (1200 ms fits in 28 bits)
    localparam int unsigned CNT_W = 32;

    // ------------------------------------------------------------
    // Configuration byte layout
    // ------------------------------------------------------------
    localparam int unsigned CFG_HALT_BIT = 0;     // Low power halt request
    localparam int unsigned CFG_ALARM_MODE_BIT = 1; // 0 comparator, 1 interrupt
    localparam int unsigned CFG_POL_BIT = 2;      // Alarm pin polarity, stored only
    localparam int unsigned CFG_FT_LO_BIT = 3;    // Fault tolerance, stored only
    localparam int unsigned CFG_FT_HI_BIT = 4;
    localparam int unsigned CFG_WIDTH_LO_BIT = 5; // Width select low
    localparam int unsigned CFG_WIDTH_HI_BIT = 6; // Width select high
    localparam int unsigned CFG_RSVD_BIT = 7;     // Always reads zero
    localparam logic [7:0] CFG_RESET = 8'h00;     // 9-bit, active, comparator
    localparam logic [7:0] CFG_WRITE_MASK = 8'h7f; // Reserved bit not stored

    // ------------------------------------------------------------
    // Result word
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // Kept-bit masks per width code: 9, 10, 11, 12 bits
    localparam logic [15:0] MASK_9BIT = 16'hff80;
    localparam logic [15:0] MASK_10BIT = 16'hffc0;
    localparam logic [15:0] MASK_11BIT = 16'hffe0;
    localparam logic [15:0] MASK_12BIT = 16'hfff0;

    // Width select codes
    localparam logic [1:0] WIDTH_9 = 2'h0;
    localparam logic [1:0] WIDTH_10 = 2'h1;
    localparam logic [1:0] WIDTH_11 = 2'h2;
    localparam logic [1:0] WIDTH_12 = 2'h3;

    // Sequencer states
    typedef enum logic {
        TCSC_CONVERT,
        TCSC_STANDBY
    } tcsc_state_e;

endpackage
